// ===== core/fwsb_ctrl.sv
// Host controller that commands the flash and polls its write-status bits
`timescale 1ns/1ps
`default_nettype none
// Function
// - Host double-reads, compares toggle bit; unchanged means done.
// - Still toggling: check timeout bit, recheck toggle, fail then reset.
// - Host restarts from the double read after leaving polling.
// - After timeout failure host writes the reset command.
// - Host may skip window bit only with sub-50 us command spacing.
// - Host checks window bit before and after each added sector command; code sends one sector per order, reads it on first and final steady poll reads.
// - Status valid only at programmed address or erasing sector address.
module fwsb_ctrl
  import fwsb_pkg::*;
(
  input  wire logic        clk,          // 200 MHz clock
  input  wire logic        rst,          // Async reset, active high
  input  wire logic        req_valid,    // Order strobe
  input  wire fwsb_req_t   req,          // Order contents
  output logic             req_ready,    // Idle, order accepted
  output logic             rsp_valid,    // One-cycle outcome pulse
  output fwsb_rsp_t        rsp,          // Outcome contents
  output fwsb_pins_t       pins,         // Flash control, address, data out
  input  wire logic [7:0]  data_lines_in // Flash data lines
);

  typedef enum logic [2:0] {
    FWSB_IDLE, FWSB_WR, FWSB_RD, FWSB_GAP, FWSB_DONE
  } fwsb_state_t;

  // Bus cycle phase and sequencing state
  fwsb_state_t state_q;
  fwsb_req_t   req_q;
  logic [2:0]  step_q;       // Command write index
  logic [2:0]  len_q;        // Command write count
  logic [7:0]  tmr_q;
  logic [1:0]  reads_q;      // Reads since poll (re)start, stops at 1
  logic        prev_tog_q;   // Toggle bit one from previous read
  logic        fail_seen_q;  // Timeout bit seen while still toggling
  logic        win_before_q; // Window bit from the first read of the poll
  logic        polling_q;
  logic        result_ok_q;
  logic        result_fail_q;
  logic        result_win_q;
  logic [7:0]  last_q;

  logic [18:0] wr_addr;
  logic [7:0]  wr_data;
  logic        tog_now;

  // Command table: unlock pair, opcode, then operand writes
  always_comb begin
    wr_addr = ADDR_UNLOCK1;
    wr_data = CMD_UNLOCK1;
    case (step_q)
      3'h0: begin wr_addr = ADDR_UNLOCK1; wr_data = CMD_UNLOCK1; end
      3'h1: begin wr_addr = ADDR_UNLOCK2; wr_data = CMD_UNLOCK2; end
      3'h2: begin
        wr_addr = ADDR_UNLOCK1;
        wr_data = (req_q.op == FWSB_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
      end
      3'h3: begin
        wr_addr = (req_q.op == FWSB_OP_PROGRAM) ? req_q.addr : ADDR_UNLOCK1;
        wr_data = (req_q.op == FWSB_OP_PROGRAM) ? req_q.data : CMD_UNLOCK1;
      end
      3'h4: begin wr_addr = ADDR_UNLOCK2; wr_data = CMD_UNLOCK2; end
      3'h5: begin
        wr_addr = (req_q.op == FWSB_OP_SECTOR_ERASE) ? req_q.addr : ADDR_UNLOCK1;
        wr_data = (req_q.op == FWSB_OP_SECTOR_ERASE) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
      end
      3'h6: begin wr_addr = '0; wr_data = CMD_RESET; end
      default: begin wr_addr = ADDR_UNLOCK1; wr_data = CMD_UNLOCK1; end
    endcase
  end

  assign tog_now = data_lines_in[TOGGLE_ONE_POS];

  // Bus sequencer; reads always target the order's address so that
  // the sector toggle and data-polling bits are valid there
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q       <= FWSB_IDLE;
      req_q         <= '0;
      step_q        <= 3'h0;
      len_q         <= 3'h0;
      tmr_q         <= 8'h00;
      reads_q       <= 2'h0;
      prev_tog_q    <= 1'b0;
      fail_seen_q   <= 1'b0;
      win_before_q  <= 1'b0;
      polling_q     <= 1'b0;
      result_ok_q   <= 1'b0;
      result_fail_q <= 1'b0;
      result_win_q  <= 1'b0;
      last_q        <= 8'h00;
      pins          <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dout: '0, doe: 1'b0};
      req_ready     <= 1'b1;
      rsp_valid     <= 1'b0;
      rsp           <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        FWSB_IDLE: begin
          if (req_valid) begin
            req_q         <= req;
            req_ready     <= 1'b0;
            reads_q       <= 2'h0;
            fail_seen_q   <= 1'b0;
            result_fail_q <= 1'b0;
            result_ok_q   <= 1'b0;
            if (req.op == FWSB_OP_POLL) begin
              polling_q <= 1'b1;
              state_q   <= FWSB_GAP;
              tmr_q     <= 8'h00;
            end else begin
              polling_q <= 1'b0;
              step_q    <= 3'h0;
              len_q     <= (req.op == FWSB_OP_PROGRAM) ? 3'h4 : 3'h6;
              state_q   <= FWSB_GAP;
              tmr_q     <= 8'h00;
            end
          end
        end
        FWSB_GAP: begin
          pins.ce_n <= 1'b1;
          pins.oe_n <= 1'b1;
          pins.we_n <= 1'b1;
          pins.doe  <= 1'b0;
          if (tmr_q < 8'(RECOVER_CYC)) begin
            tmr_q <= tmr_q + 8'h01;
          end else begin
            tmr_q <= 8'h00;
            if (!polling_q) begin
              pins.addr <= wr_addr;
              pins.dout <= wr_data;
              pins.doe  <= 1'b1;
              pins.ce_n <= 1'b0;
              pins.we_n <= 1'b0;
              state_q   <= FWSB_WR;
            end else begin
              pins.addr <= req_q.addr;
              pins.ce_n <= 1'b0;
              pins.oe_n <= 1'b0;
              state_q   <= FWSB_RD;
            end
          end
        end
        FWSB_WR: begin
          if (tmr_q < 8'(STROBE_CYC)) begin
            tmr_q <= tmr_q + 8'h01;
          end else begin
            // Rising write strobe latches the byte
            tmr_q     <= 8'h00;
            pins.we_n <= 1'b1;
            state_q   <= FWSB_GAP;
            if (step_q == 3'h6 || step_q + 3'h1 == len_q) begin
              polling_q <= (step_q != 3'h6);
              reads_q   <= 2'h0;
              if (step_q == 3'h6) state_q <= FWSB_DONE;
            end else begin
              step_q <= step_q + 3'h1;
            end
          end
        end
        FWSB_RD: begin
          if (tmr_q < 8'(STROBE_CYC)) begin
            tmr_q <= tmr_q + 8'h01;
          end else begin
            // Sample at end of read strobe; each full strobe is one toggle step
            tmr_q      <= 8'h00;
            pins.oe_n  <= 1'b1;
            pins.ce_n  <= 1'b1;
            last_q     <= data_lines_in;
            prev_tog_q <= tog_now;
            state_q    <= FWSB_GAP;
            if (reads_q == 2'h0) begin
              reads_q      <= 2'h1;
              win_before_q <= data_lines_in[ERASE_WIN_POS];
            end else if (tog_now == prev_tog_q) begin
              // Steady toggle is success even after the timeout bit was seen
              result_ok_q  <= 1'b1;
              result_win_q <= data_lines_in[ERASE_WIN_POS];
              state_q      <= FWSB_DONE;
            end else if (fail_seen_q) begin
              // Still toggling after timeout bit: failure, reset flash
              result_fail_q <= 1'b1;
              polling_q     <= 1'b0;
              step_q        <= 3'h6;
            end else if (data_lines_in[TIMEOUT_FAIL_POS]) begin
              fail_seen_q <= 1'b1;
            end
          end
        end
        FWSB_DONE: begin
          // Reset write comes here with no gap, so let go of the bus now
          pins.ce_n <= 1'b1;
          pins.we_n <= 1'b1;
          pins.doe  <= 1'b0;
          rsp_valid <= 1'b1;
          rsp       <= '{ok: result_ok_q & ~result_fail_q, fail: result_fail_q,
                         window_closed: result_win_q | win_before_q, last_read: last_q};
          req_ready <= 1'b1;
          polling_q <= 1'b0;
          state_q   <= FWSB_IDLE;
        end
        default: state_q <= FWSB_IDLE;
      endcase
    end
  end

endmodule : fwsb_ctrl
`default_nettype wire

// ===== inc/fwsb_pkg.sv
// Package for the flash write-status polling controller
package fwsb_pkg;

  // Status bit positions on the data lines
  localparam int unsigned DATA_POLLING_POS = 7;
  localparam int unsigned TOGGLE_ONE_POS   = 6;
  localparam int unsigned TIMEOUT_FAIL_POS = 5;
  localparam int unsigned ERASE_WIN_POS    = 3;
  localparam int unsigned SECTOR_TOG_POS   = 2;

  // Command bytes and unlock addresses
  localparam logic [7:0]  CMD_RESET        = 8'hF0;
  localparam logic [7:0]  CMD_UNLOCK1      = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2      = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM      = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
  localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0]  CMD_CHIP_ERASE   = 8'h10;
  localparam logic [18:0] ADDR_UNLOCK1     = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2     = 19'h002AA;

  // Bus timing in clock cycles (200 MHz clock)
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned STROBE_NS        = 60;
  localparam int unsigned STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RECOVER_NS       = 20;
  localparam int unsigned RECOVER_CYC      = (RECOVER_NS * CLK_MHZ + 999) / 1000;

  // User orders
  typedef enum logic [1:0] {
    FWSB_OP_PROGRAM,
    FWSB_OP_SECTOR_ERASE,
    FWSB_OP_CHIP_ERASE,
    FWSB_OP_POLL
  } fwsb_op_t;

  typedef struct packed {
    fwsb_op_t    op;
    logic [18:0] addr;
    logic [7:0]  data;
  } fwsb_req_t;

  // Outcome of an order
  typedef struct packed {
    logic       ok;
    logic       fail;
    logic       window_closed;
    logic [7:0] last_read;
  } fwsb_rsp_t;

  // Flash bus pins
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [18:0] addr;
    logic [7:0]  dout;
    logic        doe;
  } fwsb_pins_t;

endpackage : fwsb_pkg

// ===== sim/fwsb_ctrl_assertions.sv
// Port checker for the flash status-polling controller
`timescale 1ns/1ps
`default_nettype none
module fwsb_ctrl_chk
  import fwsb_pkg::*;
(
  input wire logic       clk,          // Clock
  input wire logic       rst,          // Reset
  input wire logic       req_valid,    // Order strobe
  input wire fwsb_req_t  req,          // Order
  input wire logic       req_ready,    // Idle
  input wire logic       rsp_valid,    // Outcome pulse
  input wire fwsb_rsp_t  rsp,          // Outcome
  input wire fwsb_pins_t pins,         // Flash pins
  input wire logic [7:0] data_lines_in // Flash data
);
  logic [7:0]  r0_q, r1_q; // Two latest reads
  logic [1:0]  n_q;        // Reads since take, saturating
  logic        f0_q;       // Reset command seen
  logic [18:0] a_q;        // Order address
  logic        oe_n_prev_q; // Read strobe one cycle back
  logic [7:0]  data_prev_q; // Data lines one cycle back
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Per-order read count and reset-command tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_q  <= 2'h0;
      f0_q <= 1'b0;
      a_q  <= 19'h00000;
    end else if (req_valid && req_ready) begin
      n_q  <= 2'h0;
      f0_q <= 1'b0;
      a_q  <= req.addr;
    end else begin
      if (pins.oe_n && !oe_n_prev_q && n_q != 2'h3) n_q <= n_q + 2'h1;
      if (!pins.we_n && pins.dout == CMD_RESET) f0_q <= 1'b1;
    end
  end
  // Byte sampled on the last low cycle of each read
  always_ff @(posedge clk) begin
    oe_n_prev_q <= pins.oe_n;
    data_prev_q <= data_lines_in;
    if (pins.oe_n && !oe_n_prev_q) begin
      r0_q <= r1_q;
      r1_q <= data_prev_q;
    end
  end
  read_addr_a: assert property (!pins.oe_n |-> pins.addr == a_q)
    else $error("read away from order address");
  no_fight_a: assert property (!pins.oe_n |-> !pins.doe && pins.we_n)
    else $error("data driven during read");
  read_width_a: assert property ($fell(pins.oe_n) |=> !pins.oe_n [*8])
    else $error("read strobe too short");
  ok_match_a: assert property (rsp_valid && rsp.ok |=> r0_q[6] == r1_q[6])
    else $error("done without two equal toggle reads");
  fail_diff_a: assert property (rsp_valid && rsp.fail |=> r0_q[6] != r1_q[6])
    else $error("fail while toggle bit steady");
  fail_reset_a: assert property (rsp_valid && rsp.fail |-> f0_q)
    else $error("fail without reset command");
  two_reads_a: assert property (rsp_valid |=> n_q >= 2'h2)
    else $error("outcome before double read");
  ok_excl_a: assert property (rsp_valid |-> !(rsp.ok && rsp.fail))
    else $error("ok and fail together");
  cover property (rsp_valid && rsp.ok);
  cover property (rsp_valid && rsp.fail);
  cover property (rsp_valid && rsp.window_closed);
endmodule : fwsb_ctrl_chk
bind fwsb_ctrl fwsb_ctrl_chk fwsb_ctrl_chk_inst (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .pins(pins), .data_lines_in(data_lines_in));
`default_nettype wire

// ===== sim/fwsb_flash_model.sv
// Behavioural flash answering the controller's bus cycles
`timescale 1ns/1ps
`default_nettype none
module fwsb_flash_model
  import fwsb_pkg::*;
(
  input  wire fwsb_pins_t pins,      // Bus from controller
  output logic [7:0]      data_lines // Read data
);
  int         busy = 0;  // Reads left while running
  int         n_rd = 0;  // Completed reads
  logic       fail = 1'b0, t1 = 1'b0, t2 = 1'b0, ers = 1'b0, prg = 1'b0, setup = 1'b0;
  logic [7:0] mem = 8'hFF, pd = 8'h00, last = 8'h00, val;
  logic       prot = 1'b0, susp = 1'b0; // Locked target, erase suspended
  // Commands latch at the end of the write strobe
  always @(posedge pins.we_n) begin
    if (ers && busy > 0) begin
      // Erase under way: every command is dropped
      prg = 1'b0;
    end else if (prg) begin
      pd = pins.dout;
      if (!prot) begin
        fail = |(pins.dout & ~mem);
        mem = mem & pins.dout;
      end
      prg = 1'b0;
    end else if (pins.dout == CMD_RESET) begin
      fail = 1'b0;
      busy = 0;
    end else if (pins.dout == CMD_PROGRAM) prg = 1'b1;
    else if (pins.dout == CMD_ERASE_SETUP) setup = 1'b1;
    else if (setup && (pins.dout == CMD_SECTOR_ERASE || pins.dout == CMD_CHIP_ERASE)) begin
      ers = 1'b1;
      if (!prot) mem = 8'hFF;
      setup = 1'b0;
    end
  end
  // Toggles advance only when a read completes
  always @(posedge pins.oe_n) begin
    n_rd = n_rd + 1;
    last = val;
    if (busy > 0 || fail) begin
      if (!susp) t1 = ~t1;
      t2 = t2 ^ ers;
      busy = fail ? busy : busy - 1;
    end
    if (busy == 0 && !fail) ers = 1'b0;
  end
  // Status at any address while running; released bus shows the inverse
  always_comb begin
    val = (busy > 0 || fail) ? {ers ? 1'b0 : ~pd[7], t1, fail, 1'b0, ers, t2, 2'b00} : mem;
    data_lines = (!pins.ce_n && !pins.oe_n) ? val : ~last;
  end
endmodule : fwsb_flash_model
`default_nettype wire

// ===== sim/fwsb_ctrl_tb_top.sv
// Self-checking bench for the flash status-polling controller
`timescale 1ns/1ps
`default_nettype none
module fwsb_ctrl_tb_top
  import fwsb_pkg::*;
;
  logic       clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, rsp_valid;
  fwsb_req_t  req = '0;
  fwsb_rsp_t  rsp;
  fwsb_pins_t pins;
  logic [7:0] data_lines;
  int         errors = 0, n_compared = 0, cyc = 0, n0;
  always #2.5 clk = ~clk;
  fwsb_ctrl fwsb_ctrl_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .data_lines_in(data_lines));
  fwsb_flash_model fwsb_flash_model_inst (.pins(pins), .data_lines(data_lines));
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk
  // One order; the model stays busy for b reads
  task automatic order(input fwsb_op_t op, input logic [18:0] a, input logic [7:0] d, input int b);
    fwsb_flash_model_inst.busy = b;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op, a, d};
    @(negedge clk);
    req_valid = 1'b0;
    chk("ready while busy", 8'h00, {7'h00, req_ready});
    while (rsp_valid !== 1'b1) @(negedge clk);
    chk("ready after answer", 8'h01, {7'h00, req_ready});
  endtask : order
  task automatic s_program;
    order(FWSB_OP_PROGRAM, 19'h12345, 8'h3C, 3);
    chk("program ok", 8'h01, {7'h00, rsp.ok});
    order(FWSB_OP_POLL, 19'h12345, 8'h00, 0);
    chk("program data", 8'h3C, rsp.last_read);
  endtask : s_program
  // Setting a cleared bit must fail, then the reset restores array reads
  task automatic s_fail;
    order(FWSB_OP_PROGRAM, 19'h12345, 8'hFF, 2);
    chk("fail flag", 8'h01, {7'h00, rsp.fail});
    order(FWSB_OP_POLL, 19'h12345, 8'h00, 0);
    chk("after reset", 8'h3C, rsp.last_read);
  endtask : s_fail
  task automatic s_erase;
    order(FWSB_OP_SECTOR_ERASE, 19'h20000, 8'h00, 4);
    chk("erase window", 8'h01, {7'h00, rsp.window_closed});
    order(FWSB_OP_CHIP_ERASE, 19'h00000, 8'h00, 0);
    chk("chip erase ok", 8'h01, {7'h00, rsp.ok});
    order(FWSB_OP_POLL, 19'h12345, 8'h00, 0);
    chk("erased data", 8'hFF, rsp.last_read);
  endtask : s_erase
  // Resumed polling needs the toggling reads plus two equal ones
  task automatic s_restart;
    n0 = fwsb_flash_model_inst.n_rd;
    order(FWSB_OP_POLL, 19'h20000, 8'h00, 5);
    chk("poll reads", 8'h07, 8'(fwsb_flash_model_inst.n_rd - n0));
  endtask : s_restart
  // Locked target: erase and program both leave the byte alone
  task automatic s_protect;
    order(FWSB_OP_PROGRAM, 19'h12345, 8'h0F, 0);
    chk("clear bits", 8'h0F, rsp.last_read);
    fwsb_flash_model_inst.prot = 1'b1;
    order(FWSB_OP_SECTOR_ERASE, 19'h12345, 8'h00, 2);
    chk("locked erase", 8'h0F, rsp.last_read);
    order(FWSB_OP_PROGRAM, 19'h12345, 8'h00, 2);
    chk("locked program", 8'h0F, rsp.last_read);
    fwsb_flash_model_inst.prot = 1'b0;
  endtask : s_protect
  // Suspended erase: toggle bit one stands, so two reads end the poll
  task automatic s_suspend;
    fwsb_flash_model_inst.susp = 1'b1;
    n0 = fwsb_flash_model_inst.n_rd;
    order(FWSB_OP_POLL, 19'h12345, 8'h00, 4);
    chk("suspend reads", 8'h02, 8'(fwsb_flash_model_inst.n_rd - n0));
    fwsb_flash_model_inst.susp = 1'b0;
    fwsb_flash_model_inst.busy = 0;
  endtask : s_suspend
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    s_program;
    s_fail;
    s_erase;
    s_restart;
    s_protect;
    s_suspend;
    test_done;
  end
endmodule : fwsb_ctrl_tb_top
`default_nettype wire
